// >>> src/pmtr_unit.sv
/*
 * Program memory table read unit with program fetch, the table pointer,
 * the table high byte latch and the shared debug and programming pins.
 * Assumes the core holds a request stable until tblDone and that the
 * serial protocols themselves live outside, behind debugActive/progWr.
 */
// Contract
// - Sixteen thousand words of sixteen bits.
// - Fetch restarts at word zero after reset.
// - Table address joins low and high pointers.
// - Low byte goes to operand register.
// - High byte goes to the latch.
// - Every table read takes two cycles.
// - Software reads and writes the latch.
// - Normal form sector zero; extended any sector.
// - Programming uses one data pin, one clock.
// - Debug uses one data pin, clock input.
// - Debug use disables other pin functions.
// - Debug pins double as programming pins.
`timescale 1ns/1ps
module pmtr_unit
    import pmtr_pkg::*;
#(
    parameter int ADDR_W = PMTR_ADDR_W
) (
    input  wire logic              clock,
    input  wire logic              resetn,
    input  wire logic              clockEn,
    input  wire logic [ADDR_W-1:0] fetchAddr,
    input  wire logic              fetchJump,
    output logic      [ADDR_W-1:0] pcOut,
    output logic      [15:0]       instrWord,
    input  wire logic [7:0]        ptrLow,
    input  wire logic [7:0]        ptrHigh,
    input  wire pmtr_req_s         tblReq,
    output logic                   tblBusy,
    output logic                   tblDone,
    output logic                   tblIllegal,
    output pmtr_wr_s               regWr,
    input  wire logic              latchWrEn,
    input  wire logic [7:0]        latchWrData,
    output logic      [7:0]        latchRdData,
    input  wire logic              debugActive,
    input  wire logic              debugClockPin,
    input  wire logic              debugDataIn,
    output logic                   debugDataOut,
    output logic                   debugDataOe,
    input  wire logic              serialDataOut,
    input  wire logic              serialDataOe,
    output logic                   serialClock,
    output logic                   serialData,
    input  wire logic              gpioDataOut,
    input  wire logic              gpioDataOe,
    input  wire logic              gpioClockOut,
    input  wire logic              gpioClockOe,
    output logic                   debugClockOut,
    output logic                   debugClockOe,
    input  wire logic              progWr,
    input  wire logic [ADDR_W-1:0] progAddr,
    input  wire logic [15:0]       progData
);

    typedef enum logic [0:0] {ST_IDLE, ST_XFER} pmtr_state_e;

    initial begin
        if (ADDR_W != PMTR_ADDR_W) begin
            $error("pmtr_unit: table pointer must be 14 bits");
        end
    end

    function automatic logic isExtended(input pmtr_op_e op);
        return op == PMTR_OP_EXTENDED_TABLE_READ_OP || op == PMTR_OP_EXTENDED_TABLE_READ_OP_LAST;
    endfunction

    pmtr_state_e       state_ff;
    pmtr_state_e       nxt_state;
    logic [ADDR_W-1:0] pc_ff;
    logic [7:0]        latch_ff;
    pmtr_req_s         req_ff;
    pmtr_wr_s          wr_ff;
    logic              illegal_ff;
    logic [15:0]       romData;

    // Table address: high pointer's spare upper bits are dropped.
    wire [ADDR_W-1:0] tblAddr  = {ptrHigh[ADDR_W-9:0], ptrLow};
    wire              reqValid = tblReq.op != PMTR_OP_NONE;
    wire              reqOk    = isExtended(tblReq.op)
                               || tblReq.sector == 2'h0;
    wire              startTbl = state_ff == ST_IDLE && reqValid;
    wire              romInTbl = startTbl && reqOk;
    wire [ADDR_W-1:0] romAddr  = romInTbl ? tblAddr : pc_ff;

    assign nxt_state   = startTbl ? ST_XFER : ST_IDLE;
    assign tblBusy     = state_ff == ST_XFER;
    assign tblDone     = state_ff == ST_XFER;
    assign tblIllegal  = illegal_ff;
    assign regWr       = wr_ff;
    assign latchRdData = latch_ff;
    assign pcOut       = pc_ff;
    assign instrWord   = romData;

    // Table reads borrow the fetch port, which is why the core stalls.
    pmtr_rom #(
        .DEPTH  (PMTR_WORDS),
        .ADDR_W (ADDR_W),
        .DATA_W (PMTR_DATA_W)
    ) u_rom (
        .clock   (clock),
        .clockEn (clockEn),
        .rdAddr  (romAddr),
        .rdData  (romData),
        .wrEn    (progWr),
        .wrAddr  (progAddr),
        .wrData  (progData)
    );

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_ff <= ST_IDLE;
        end else if (clockEn) begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pc_ff <= PMTR_RESET_VEC;
        end else if (clockEn) begin
            if (fetchJump) begin
                pc_ff <= fetchAddr;
            end else if (!startTbl && state_ff == ST_IDLE) begin
                pc_ff <= pc_ff + 14'h0001;
            end
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            req_ff     <= '0;
            illegal_ff <= 1'b0;
        end else if (clockEn) begin
            if (startTbl) begin
                req_ff <= tblReq;
            end
            illegal_ff <= startTbl && !reqOk;
        end
    end

    // Software write to the latch loses to a table read landing together.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            latch_ff <= PMTR_TABLE_HIGH_BYTE_LATCH_RST;
            wr_ff    <= '0;
        end else if (clockEn) begin
            wr_ff.valid <= 1'b0;
            if (state_ff == ST_XFER && !illegal_ff) begin
                latch_ff      <= romData[PMTR_HI_POS +: 8];
                wr_ff.valid   <= 1'b1;
                wr_ff.sector  <= req_ff.sector;
                wr_ff.regAddr <= req_ff.regAddr;
                wr_ff.data    <= romData[PMTR_LO_POS +: 8];
            end else if (latchWrEn) begin
                latch_ff <= latchWrData;
            end
        end
    end

    // Shared pins: debug owns both pins and locks out the port functions.
    assign debugDataOut  = debugActive ? serialDataOut : gpioDataOut;
    assign debugDataOe   = debugActive ? serialDataOe  : gpioDataOe;
    assign debugClockOut = gpioClockOut;
    assign debugClockOe  = debugActive ? 1'b0 : gpioClockOe;
    assign serialClock   = debugActive & debugClockPin;
    assign serialData    = debugActive & debugDataIn;

    table_two_cycle_a: assert property (
        @(posedge clock) disable iff (!resetn)
        clockEn && startTbl |=> tblDone && tblBusy)
        else $error("table read did not reach its second cycle");

    // A frozen clock enable keeps the second cycle up, so only count live ones.
    table_single_done_a: assert property (
        @(posedge clock) disable iff (!resetn)
        clockEn && tblDone |=> !tblDone)
        else $error("table read took more than two cycles");

    latch_load_a: assert property (
        @(posedge clock) disable iff (!resetn)
        clockEn && tblDone && !illegal_ff |=>
            latchRdData == $past(romData[PMTR_HI_POS +: 8]))
        else $error("latch not loaded with high byte");

    low_byte_a: assert property (
        @(posedge clock) disable iff (!resetn)
        clockEn && tblDone && !illegal_ff |=>
            regWr.valid && regWr.data == $past(romData[PMTR_LO_POS +: 8]))
        else $error("low byte not written");

    sector_check_a: assert property (
        @(posedge clock) disable iff (!resetn)
        clockEn && startTbl && !isExtended(tblReq.op)
            && tblReq.sector != 2'h0 |=> ##1 !regWr.valid)
        else $error("normal table read wrote outside sector zero");

    latch_write_a: assert property (
        @(posedge clock) disable iff (!resetn)
        clockEn && latchWrEn && !tblDone |=> latchRdData == $past(latchWrData))
        else $error("latch write lost");

    pin_lockout_a: assert property (
        @(posedge clock) disable iff (!resetn)
        debugActive |-> !debugClockOe && debugDataOe == serialDataOe
            && debugDataOut == serialDataOut)
        else $error("shared pin driven by port during debug");

    reset_vector_a: assert property (
        @(posedge clock)
        $rose(resetn) |-> pcOut == PMTR_RESET_VEC)
        else $error("fetch did not start at vector");

    table_addr_a: assert property (
        @(posedge clock) disable iff (!resetn)
        romInTbl |-> romAddr == {ptrHigh[ADDR_W-9:0], ptrLow})
        else $error("table address wrong");

endmodule

// >>> src/pmtr_pkg.sv
/*
 * Package of the program memory table read unit: sizes, reset values,
 * timing counts, operation codes and the request and answer carriers.
 * Assumes nothing beyond a SystemVerilog tool.
 */
package pmtr_pkg;

    localparam int          PMTR_WORDS      = 16384;
    localparam int          PMTR_ADDR_W     = 14;
    localparam int          PMTR_DATA_W     = 16;
    localparam logic [13:0] PMTR_RESET_VEC  = 14'h0000;
    localparam logic [7:0]  PMTR_TABLE_HIGH_BYTE_LATCH_RST   = 8'h00;
    localparam logic [7:0]  PMTR_PTR_RST    = 8'h00;
    localparam int          PMTR_TBL_CYCLES = 2;
    localparam int          PMTR_SECT_W     = 2;
    localparam int          PMTR_LO_POS     = 0;
    localparam int          PMTR_HI_POS     = 8;

    typedef enum logic [2:0] {
        PMTR_OP_NONE,
        PMTR_OP_TABRD,
        PMTR_OP_TABRD_LAST,
        PMTR_OP_EXTENDED_TABLE_READ_OP,
        PMTR_OP_EXTENDED_TABLE_READ_OP_LAST
    } pmtr_op_e;

    typedef struct packed {
        pmtr_op_e           op;
        logic [1:0]         sector;
        logic [7:0]         regAddr;
    } pmtr_req_s;

    typedef struct packed {
        logic               valid;
        logic [1:0]         sector;
        logic [7:0]         regAddr;
        logic [7:0]         data;
    } pmtr_wr_s;

endpackage

// >>> src/pmtr_rom.sv
/*
 * Program memory array, one word wide, with registered read data.
 * Assumes a write port driven by the programming path only.
 */
`timescale 1ns/1ps
module pmtr_rom
    import pmtr_pkg::*;
#(
    parameter int DEPTH  = PMTR_WORDS,
    parameter int ADDR_W = PMTR_ADDR_W,
    parameter int DATA_W = PMTR_DATA_W
) (
    input  wire logic              clock,
    input  wire logic              clockEn,
    input  wire logic [ADDR_W-1:0] rdAddr,
    output logic      [DATA_W-1:0] rdData,
    input  wire logic              wrEn,
    input  wire logic [ADDR_W-1:0] wrAddr,
    input  wire logic [DATA_W-1:0] wrData
);

    logic [DATA_W-1:0] mem [DEPTH];

    initial begin
        if (DEPTH > (1 << ADDR_W)) begin
            $error("pmtr_rom: depth exceeds address range");
        end
    end

    // No reset on the array output, so the array maps onto block memory.
    always_ff @(posedge clock) begin
        if (clockEn) begin
            if (wrEn) begin
                mem[wrAddr] <= wrData;
            end
            rdData <= mem[rdAddr];
        end
    end

endmodule

// >>> tb/pmtr_core_model.sv
/*
 * Behavioural core that issues one table read at a time to the unit.
 * Assumes the bench calls issue() and drives all other inputs itself.
 */
`timescale 1ns/1ps
module pmtr_core_model
    import pmtr_pkg::*;
(
    input  wire logic clock,
    input  wire logic tblDone,
    input  wire logic tblIllegal,
    output pmtr_req_s tblReq
);
    int   waitCycles;
    logic refused;

    initial tblReq = '0;

    task automatic issue(input pmtr_req_s r);
        @(negedge clock);
        tblReq = r;
        waitCycles = 0;
        refused = 1'b0;
        // The core stalls and holds the request until the unit answers.
        while (tblDone !== 1'b1 && refused !== 1'b1 && waitCycles < 8) begin
            @(posedge clock);
            waitCycles++;
            refused = tblIllegal;
        end
        @(negedge clock);
        // Released fields are inverted so stale values never look valid.
        tblReq = '{op: PMTR_OP_NONE, sector: ~r.sector, regAddr: ~r.regAddr};
    endtask
endmodule

// >>> tb/program_memory_table_read_test.sv
/*
 * Self-checking bench of the table read unit and its shared pins.
 * Assumes pmtr_core_model drives the table request port.
 */
`timescale 1ns/1ps
module program_memory_table_read_test
    import pmtr_pkg::*;
;
    logic clock = 0, resetn = 0, progWr = 0, latchWrEn = 0, debugActive = 0;
    logic dck = 0, ddi = 0, sdo = 0, soe = 0, gdo = 0, goe = 0;
    logic gco = 0, gcoe = 0, tblBusy, tblDone, tblIllegal;
    logic debugDataOut, debugDataOe, serialClock, serialData;
    logic debugClockOut, debugClockOe;
    logic [13:0] progAddr = 0, pcOut, addrs [8];
    logic [15:0] progData = 0, instrWord, rnd = 16'h0034, mem [logic [13:0]];
    logic [7:0]  ptrLow = 0, ptrHigh = 0, latchWrData = 0, latchRdData;
    logic [7:0]  lastHigh = 0;
    logic [25:0] expQ [$], e;
    pmtr_req_s   tblReq, r;
    pmtr_wr_s    regWr;
    int          fails = 0, cmp_count = 0, cycles = 0;

    always #20 clock = ~clock;

    pmtr_unit dut_u (.clock(clock), .resetn(resetn), .clockEn(1'b1),
        .fetchAddr(14'h0000), .fetchJump(1'b0), .pcOut(pcOut),
        .instrWord(instrWord), .ptrLow(ptrLow), .ptrHigh(ptrHigh),
        .tblReq(tblReq), .tblBusy(tblBusy), .tblDone(tblDone),
        .tblIllegal(tblIllegal), .regWr(regWr), .latchWrEn(latchWrEn),
        .latchWrData(latchWrData), .latchRdData(latchRdData),
        .debugActive(debugActive), .debugClockPin(dck), .debugDataIn(ddi),
        .debugDataOut(debugDataOut), .debugDataOe(debugDataOe),
        .serialDataOut(sdo), .serialDataOe(soe), .serialClock(serialClock),
        .serialData(serialData), .gpioDataOut(gdo), .gpioDataOe(goe),
        .gpioClockOut(gco), .gpioClockOe(gcoe), .debugClockOut(debugClockOut),
        .debugClockOe(debugClockOe), .progWr(progWr), .progAddr(progAddr),
        .progData(progData));

    pmtr_core_model core_u (.clock(clock), .tblDone(tblDone),
        .tblIllegal(tblIllegal), .tblReq(tblReq));

    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("fails %0d cmp_count %0d", fails, cmp_count);
        if (fails == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic pwrite(input logic [13:0] a, input logic [15:0] d);
        @(negedge clock);
        {progWr, progAddr, progData} = {1'b1, a, d};
        mem[a] = d;
        @(negedge clock);
        progWr = 1'b0;
    endtask

    // Sets the pointer with junk in the ignored top bits, then reads.
    task automatic tread(input pmtr_op_e op, input logic [1:0] sec,
                         input logic [13:0] a, input logic [1:0] junk);
        logic ok;
        ok = (op > PMTR_OP_TABRD_LAST) || sec == 2'h0;
        @(negedge clock);
        ptrLow = a[7:0];
        ptrHigh = {junk, a[13:8]};
        r = '{op: op, sector: sec, regAddr: rnd[7:0]};
        if (ok) begin
            expQ.push_back({sec, r.regAddr, mem[a]});
            lastHigh = mem[a][15:8];
        end
        core_u.issue(r);
        check(core_u.refused, !ok);
        if (ok)
            check(core_u.waitCycles, PMTR_TBL_CYCLES);
        @(negedge clock);
        check(latchRdData, lastHigh);
    endtask

    always @(posedge clock) begin
        cycles++;
        if (cycles == 4000) begin
            fails++;
            stop_test();
        end
        if (resetn && tblDone === 1'b1) begin
            check(tblBusy, 1'b1);
            if (tblIllegal === 1'b0 && expQ.size() > 0)
                check(instrWord, expQ[0][15:0]);
        end
        if (resetn && regWr.valid === 1'b1) begin
            e = (expQ.size() > 0) ? expQ.pop_front() : 26'h3FFFFFF;
            check(regWr.data, e[7:0]);
            check(latchRdData, e[15:8]);
            check({regWr.sector, regWr.regAddr}, e[25:16]);
        end
    end

    initial begin
        repeat (5) @(negedge clock);
        resetn = 1'b1;
        check(pcOut, PMTR_RESET_VEC);
        check(latchRdData, PMTR_TABLE_HIGH_BYTE_LATCH_RST);
        for (int i = 0; i < 8; i++) begin
            rnd = lfsr(rnd);
            addrs[i] = (i < 2) ? {14{i[0]}} : rnd[13:0];
            pwrite(addrs[i], lfsr(rnd));
        end
        for (int i = 0; i < 8; i++) begin
            rnd = lfsr(rnd);
            tread(pmtr_op_e'(1 + i % 4), (i % 4 > 1) ? rnd[1:0] : 2'h0,
                  addrs[i], rnd[3:2]);
        end
        tread(PMTR_OP_TABRD, 2'h1, addrs[2], 2'h3);
        tread(PMTR_OP_TABRD_LAST, 2'h3, addrs[3], 2'h0);
        rnd = lfsr(rnd);
        @(negedge clock);
        {latchWrEn, latchWrData} = {1'b1, rnd[7:0]};
        @(negedge clock);
        latchWrEn = 1'b0;
        check(latchRdData, rnd[7:0]);
        for (int j = 0; j < 8; j++) begin
            rnd = lfsr(rnd);
            @(negedge clock);
            debugActive = j[0];
            {dck, ddi, sdo, soe, gdo, goe, gco, gcoe} = rnd[7:0];
            #5;
            check(serialClock, debugActive & dck);
            check(serialData, debugActive & ddi);
            check(debugClockOe, debugActive ? 1'b0 : gcoe);
            check(debugDataOe, debugActive ? soe : goe);
            check(debugDataOut, debugActive ? sdo : gdo);
            if (!debugActive)
                check(debugClockOut, gco);
        end
        repeat (4) @(negedge clock);
        check(expQ.size(), 0);
        @(negedge clock);
        resetn = 1'b0;
        repeat (2) @(negedge clock);
        resetn = 1'b1;
        check(pcOut, PMTR_RESET_VEC);
        check(latchRdData, PMTR_TABLE_HIGH_BYTE_LATCH_RST);
        repeat (2) @(negedge clock);
        stop_test();
    end
endmodule
